// ===== bench/nbfr_assertions.sv
// port-level assertions for the fast-read sequencer
module nbfr_assertions
(
   // clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // spi pins
   input wire logic        cs_n,
   input wire logic        sck,
   input wire logic [3:0]  io_out,
   input wire logic [3:0]  io_oe,
   // config, buffer port and status
   input wire logic        protect_en,
   input wire logic [11:0] buf_rd_col,
   input wire logic        read_active,
   input wire logic        quad_reject
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   a_cs_release: assert property (cs_n |=> io_oe == 4'h0)
      else $error("pins driven after deselect");
   a_ra_drop: assert property (cs_n |=> !read_active)
      else $error("read still active after deselect");
   a_oe_shape: assert property (io_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
      else $error("odd output enable pattern");
   a_reject_pulse: assert property (quad_reject |=> !quad_reject)
      else $error("refusal pulse too long");
   a_reject_guard: assert property (quad_reject |-> protect_en && io_oe == 4'h0)
      else $error("refusal without protect");
   // data moves only after a falling sck
   a_out_hold: assert property ($changed(io_out) && io_oe != 4'h0 |->
      !$past(sck) && ($past(sck, 2) || $past(sck, 3)))
      else $error("data changed off a falling edge");
   // column steps by one, or wraps to zero, while streaming
   a_col_step: assert property ($changed(buf_rd_col) && io_oe != 4'h0 && $past(io_oe) != 4'h0
      |-> buf_rd_col == $past(buf_rd_col) + 12'h001 || buf_rd_col == 12'h000)
      else $error("column did not step by one");
   // drive only inside an active read
   a_oe_active: assert property (io_oe != 4'h0 |-> read_active)
      else $error("driving outside a read");
endmodule

bind nbfr_seq nbfr_assertions u_chk (.clk(clk), .reset(reset), .cs_n(cs_n), .sck(sck),
   .io_out(io_out), .io_oe(io_oe), .protect_en(protect_en), .buf_rd_col(buf_rd_col),
   .read_active(read_active), .quad_reject(quad_reject));

// ===== bench/nbfr_host.sv
// host spi controller model that clocks frames and samples the data lines
module nbfr_host
(
   // clock
   input  wire logic       clk,
   // device drive
   input  wire logic [3:0] io_out,
   input  wire logic [3:0] io_oe,
   // spi pins
   output logic            cs_n,
   output logic            sck,
   output logic [3:0]      io_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] drv;
   logic [7:0] smp [$];
   // wire level: device wins where enabled, host elsewhere
   assign io_in = (io_oe & io_out) | (~io_oe & drv);
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      drv = 4'h0;
   end
   // mode 0: bits set while sck low, each level held two clk
   task automatic clocks(input logic [63:0] v, input int n, input int w, input bit rd);
      logic [63:0] s;
      s = v;
      for (int i = 0; i < n; i++) begin
         // released lines toggle so a stale value never reads as valid
         if (rd) drv <= ~drv;
         // two address bits per clock, io1 high
         else if (w == 2) drv <= {~drv[3:2], s[63:62]};
         else drv <= {~drv[3:1], s[63]};
         sck <= 1'b0;
         repeat (2) @(posedge clk);
         sck <= 1'b1;
         repeat (2) @(posedge clk);
         if (rd) smp.push_back({io_oe, io_out});
         s = s << w;
      end
   endtask
   // opcode, column, dummy, then n data clocks
   task automatic frame(input logic [7:0] op, input logic [15:0] col, input int dum,
                        input int w, input int n);
      smp.delete();
      cs_n <= 1'b0;
      @(posedge clk);
      clocks({op, 56'h0}, 8, 1, 1'b0);
      clocks({col, 48'h0}, (16 + dum) / w, w, 1'b0);
      clocks(64'h0, n, 1, 1'b1);
      sck <= 1'b0;
      cs_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
endmodule

// ===== bench/tb_top.sv
// self-checking bench for the buffer fast-read sequencer
module tb_top
   import nbfr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] NB = 12'h0010; // short buffer so ends and wraps come fast
   logic        clk, reset, cs_n, sck, buf_mode, protect_en, read_active, quad_reject;
   logic [3:0]  io_in, io_out, io_oe;
   logic [15:0] cur_page, buf_rd_page;
   logic [11:0] buf_rd_col;
   logic [7:0]  buf_rd_data;
   logic [7:0]  ops [7];
   int          err_count, checks, cyc, rej;

   nbfr_seq #(.BUF_BYTES(NB)) DUT (.clk(clk), .reset(reset), .cs_n(cs_n), .sck(sck),
      .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .buf_mode(buf_mode),
      .protect_en(protect_en), .cur_page(cur_page), .buf_rd_data(buf_rd_data),
      .buf_rd_col(buf_rd_col), .buf_rd_page(buf_rd_page), .read_active(read_active),
      .quad_reject(quad_reject));
   nbfr_host host (.clk(clk), .io_out(io_out), .io_oe(io_oe), .cs_n(cs_n), .sck(sck),
      .io_in(io_in));

   // array content model, a pattern per page and column
   function automatic logic [7:0] mem(input logic [15:0] p, input logic [11:0] c);
      return c[7:0] ^ {c[11:8], 4'h0} ^ p[7:0] ^ 8'h5A;
   endfunction
   // reads are served from the page buffer
   assign buf_rd_data = mem(buf_rd_page, buf_rd_col);

   always #12.5 clk = ~clk;

   // cycle ceiling and refusal pulse count
   always @(posedge clk) begin
      cyc++;
      if (quad_reject === 1'b1) rej++;
      if (cyc == 30000) begin
         err_count++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // one frame, every data clock compared with the stream model
   task automatic run(input logic [7:0] op, input logic [15:0] col, input bit bm,
                      input int nb, input bit dead);
      int w, dum, a, per, lo;
      logic [15:0] pg;
      logic [7:0] ex, g;
      logic [3:0] m, oe, ob;
      w = (op[7:4] == 4'h0) ? 1 : (op[7:4] == 4'h6) ? 4 : 2;
      dum = (op[3:0] == 4'hC) ? (bm ? 24 : 40) : (bm ? 8 : 32);
      per = 8 / w;
      lo = (w == 1) ? 1 : 0;
      m = (w == 1) ? 4'h2 : (w == 2) ? 4'h3 : 4'hF;
      buf_mode <= bm;
      cur_page <= 16'($urandom);
      @(posedge clk);
      host.frame(op, col, dum, (op == OPC_DUAL_IO) ? 2 : 1, nb * per);
      for (int i = 0; i < nb * per; i++) begin
         a = bm ? int'(col) + i / per : i / per;
         pg = cur_page + 16'(a / NB);
         ex = 8'(mem(pg, 12'(a % NB)) << (w * (i % per)));
         ob = 4'(ex >> (8 - w)) << lo;
         oe = (dead || (bm && a >= NB)) ? 4'h0 : m;
         g = host.smp[i];
         chk({g[7:4], g[3:0] & g[7:4]}, {oe, ob & oe}, "data");
      end
   endtask

   task automatic tally_and_finish();
      if (err_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      reset = 1'b1;
      buf_mode = 1'b1;
      protect_en = 1'b0;
      cur_page = 16'h0000;
      err_count = 0;
      checks = 0;
      cyc = 0;
      rej = 0;
      ops = '{OPC_FAST, OPC_FAST_EXT, OPC_DUAL, OPC_DUAL_EXT, OPC_QUAD, OPC_QUAD_EXT,
              OPC_DUAL_IO};
      void'($urandom(32'hbe55_efe4));
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      // every opcode in both modes, start column around the buffer end
      foreach (ops[k]) begin
         for (int b = 0; b < 2; b++) begin
            run(ops[k], 16'(NB - 4 + $urandom % 6), b[0], 20, 1'b0);
         end
      end
      // mid-run reset between frames returns every output to idle
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      chk({read_active, quad_reject, |buf_rd_col, |buf_rd_page, io_oe}, 8'h00, "reset");
      // quad reads refused while protected, dual still served
      protect_en <= 1'b1;
      run(OPC_QUAD, 16'h0002, 1'b1, 3, 1'b1);
      run(OPC_QUAD_EXT, 16'h0002, 1'b0, 3, 1'b1);
      run(OPC_DUAL, 16'h0001, 1'b1, 4, 1'b0);
      chk(8'(rej), 8'h02, "refusal count");
      // unknown opcode leaves the pins alone
      run(8'hA5, 16'h0000, 1'b1, 3, 1'b1);
      tally_and_finish();
   end
endmodule

// ===== core/nbfr_out_shift.sv
// output shifter that drives one, two or four data lines
module nbfr_out_shift
   import nbfr_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // control from the sequencer
   input  wire logic       load,
   input  wire logic       shift,
   input  wire logic       release_pins,
   input  wire nbfr_lane_e lane,
   input  wire logic [7:0] byte_in,
   // pin drive
   output logic [3:0]      io_out,
   output logic [3:0]      io_oe
);

   typedef struct packed {
      logic [7:0] sh;
      nbfr_lane_e lane;
      logic [3:0] io_out;
      logic [3:0] io_oe;
   } nbfr_osh_s;

   nbfr_osh_s q;
   nbfr_osh_s s;

   // top bits of a byte mapped onto the lines in use
   function automatic logic [3:0] lane_drive(input logic [7:0] v, input nbfr_lane_e l);
      case (l)
         NBFR_L4: lane_drive = v[7:4];
         NBFR_L2: lane_drive = {2'b00, v[7:6]};
         default: lane_drive = {2'b00, v[7], 1'b0};
      endcase
   endfunction

   // next state: release wins so a dead frame never drives
   always_comb begin
      logic [7:0] nsh;
      nsh = q.sh;
      s = q;
      if (release_pins) begin
         s.io_oe = 4'h0;
         s.io_out = 4'h0;
      end else if (load) begin
         s.sh = byte_in;
         s.lane = lane;
         s.io_out = lane_drive(byte_in, lane);
         case (lane)
            NBFR_L4: s.io_oe = 4'hF;
            NBFR_L2: s.io_oe = 4'h3;
            default: s.io_oe = 4'h2; // single output sits on line 1
         endcase
      end else if (shift) begin
         nsh = q.sh << lane_bits(q.lane);
         s.sh = nsh;
         s.io_out = lane_drive(nsh, q.lane);
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= s;
      end
   end

   assign io_out = q.io_out;
   assign io_oe  = q.io_oe;

endmodule

// ===== core/nbfr_seq.sv
// fast-read instruction sequencer serving the page data buffer over spi
module nbfr_seq
   import nbfr_pkg::*;
#(
   parameter logic [11:0] BUF_BYTES = BUF_BYTES_DEF,
   parameter int unsigned PAGE_W    = 16
)
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   // spi pins, sampled on clk
   input  wire logic              cs_n,
   input  wire logic              sck,
   input  wire logic [3:0]        io_in,
   output logic [3:0]             io_out,
   output logic [3:0]             io_oe,
   // configuration bits
   input  wire logic              buf_mode,
   input  wire logic              protect_en,
   // page data buffer read port
   input  wire logic [PAGE_W-1:0] cur_page,
   input  wire logic [7:0]        buf_rd_data,
   output logic [11:0]            buf_rd_col,
   output logic [PAGE_W-1:0]      buf_rd_page,
   // status
   output logic                   read_active,
   output logic                   quad_reject
);

   typedef struct packed {
      nbfr_state_e       st;
      logic              sck_q;
      logic [2:0]        cmd_cnt;
      logic [7:0]        opc;
      logic [5:0]        rx_bits;
      logic [5:0]        rx_total;
      nbfr_lane_e        lane_in;
      nbfr_lane_e        lane_out;
      logic [15:0]       col_sh;
      logic [11:0]       col;
      logic [PAGE_W-1:0] page;
      logic              cont;
      logic              done;
      logic [2:0]        beat;
      logic              reject;
      logic              active;
   } nbfr_seq_s;

   nbfr_seq_s q;
   nbfr_seq_s s;

   logic       ld;
   logic       sh;
   logic       rel;
   logic       rise;
   logic       fall;
   logic [5:0] in_step;
   logic [7:0] opc_n;
   logic       is_ext;
   logic       is_quad;
   logic       is_dual;
   logic       known;
   logic [5:0] dummy;

   // serial clock edges from the previous sample
   assign rise = sck & ~q.sck_q;
   assign fall = ~sck & q.sck_q;
   assign in_step = {2'b00, lane_bits(q.lane_in)};

   // opcode as it stands after the eighth bit
   assign opc_n = {q.opc[6:0], io_in[0]};

   // instruction decode
   always_comb begin
      is_ext  = (opc_n == OPC_FAST_EXT) | (opc_n == OPC_DUAL_EXT) | (opc_n == OPC_QUAD_EXT);
      is_quad = (opc_n == OPC_QUAD) | (opc_n == OPC_QUAD_EXT);
      is_dual = (opc_n == OPC_DUAL) | (opc_n == OPC_DUAL_EXT) | (opc_n == OPC_DUAL_IO);
      known   = is_ext | is_quad | is_dual | (opc_n == OPC_FAST);
      if (is_ext) begin
         dummy = buf_mode ? DUMMY_EXT_BUF : DUMMY_EXT_CONT;
      end else begin
         dummy = buf_mode ? DUMMY_STD_BUF : DUMMY_STD_CONT;
      end
   end

   // next state of the sequencer
   always_comb begin
      s = q;
      ld = 1'b0;
      sh = 1'b0;
      rel = 1'b0;
      s.sck_q = sck;
      s.reject = 1'b0;
      if (cs_n) begin
         s.st = ST_IDLE;
         s.active = 1'b0;
         rel = 1'b1;
      end else begin
         case (q.st)
            ST_IDLE: begin
               // a rise in the select cycle still counts as bit 7
               s.st = ST_CMD;
               s.opc = rise ? {7'h00, io_in[0]} : 8'h00;
               s.cmd_cnt = rise ? 3'h1 : 3'h0;
            end
            ST_CMD: begin
               if (rise) begin
                  s.opc = opc_n;
                  s.cmd_cnt = q.cmd_cnt + 3'h1;
                  if (q.cmd_cnt == 3'h7) begin
                     s.lane_in = (opc_n == OPC_DUAL_IO) ? NBFR_L2 : NBFR_L1;
                     if (is_quad) begin
                        s.lane_out = NBFR_L4;
                     end else if (is_dual) begin
                        s.lane_out = NBFR_L2;
                     end else begin
                        s.lane_out = NBFR_L1;
                     end
                     s.rx_total = COL_BITS + dummy;
                     s.rx_bits = 6'h00;
                     s.cont = ~buf_mode;
                     if (!known) begin
                        // other instructions belong to other blocks
                        s.st = ST_SKIP;
                     end else if (is_quad && protect_en) begin
                        s.st = ST_SKIP;
                        s.reject = 1'b1;
                     end else begin
                        s.st = ST_ADDR;
                        s.active = 1'b1;
                     end
                  end
               end
            end
            ST_ADDR: begin
               if (rise) begin
                  if (q.rx_bits < COL_BITS) begin
                     if (q.lane_in == NBFR_L2) begin
                        s.col_sh = {q.col_sh[13:0], io_in[1:0]};
                     end else begin
                        s.col_sh = {q.col_sh[14:0], io_in[0]};
                     end
                  end
                  s.rx_bits = q.rx_bits + in_step;
                  if (s.rx_bits == q.rx_total) begin
                     s.st = ST_DATA;
                     s.beat = 3'h0;
                     s.page = cur_page;
                     if (q.cont) begin
                        s.col = 12'h000;
                        s.done = 1'b0;
                     end else begin
                        s.col = s.col_sh[11:0];
                        s.done = (s.col_sh >= {4'h0, BUF_BYTES});
                     end
                  end
               end
            end
            ST_DATA: begin
               if (fall) begin
                  // beat counts bit slots modulo eight, so only three bits are kept
                  s.beat = q.beat + 3'(lane_bits(q.lane_out));
                  if (q.beat != 3'h0) begin
                     sh = 1'b1;
                  end else if (q.done) begin
                     rel = 1'b1;
                     s.beat = 3'h0;
                  end else begin
                     ld = 1'b1;
                     if (q.col == BUF_BYTES - 12'h001) begin
                        if (q.cont) begin
                           s.col = 12'h000;
                           s.page = q.page + PAGE_W'(1);
                        end else begin
                           s.done = 1'b1;
                        end
                     end else begin
                        s.col = q.col + 12'h001;
                     end
                  end
               end
            end
            ST_SKIP: begin
               s.active = 1'b0;
            end
            default: begin
               s.st = ST_IDLE;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= s;
      end
   end

   // line driver, loaded with the byte at the registered address
   nbfr_out_shift u_out (
      .clk          (clk),
      .reset        (reset),
      .load         (ld),
      .shift        (sh),
      .release_pins (rel),
      .lane         (q.lane_out),
      .byte_in      (buf_rd_data),
      .io_out       (io_out),
      .io_oe        (io_oe)
   );

   // outputs straight from state
   assign buf_rd_col  = q.col;
   assign buf_rd_page = q.page;
   assign read_active = q.active;
   assign quad_reject = q.reject;

endmodule

// ===== include/nbfr_pkg.sv
// constants, types and helpers for the buffer fast-read sequencer
package nbfr_pkg;

   // instruction codes
   localparam logic [7:0] OPC_FAST      = 8'h0B;
   localparam logic [7:0] OPC_FAST_EXT  = 8'h0C;
   localparam logic [7:0] OPC_DUAL      = 8'h3B;
   localparam logic [7:0] OPC_DUAL_EXT  = 8'h3C;
   localparam logic [7:0] OPC_QUAD      = 8'h6B;
   localparam logic [7:0] OPC_QUAD_EXT  = 8'h6C;
   localparam logic [7:0] OPC_DUAL_IO   = 8'hBB;

   // address phase lengths in bits
   localparam logic [5:0] COL_BITS       = 6'h10;
   localparam logic [5:0] DUMMY_STD_BUF  = 6'h08;
   localparam logic [5:0] DUMMY_STD_CONT = 6'h20;
   localparam logic [5:0] DUMMY_EXT_BUF  = 6'h18;
   localparam logic [5:0] DUMMY_EXT_CONT = 6'h28;

   // buffer size in bytes (2112)
   localparam logic [11:0] BUF_BYTES_DEF = 12'h840;

   // line usage of a phase
   typedef enum logic [1:0] {
      NBFR_L1 = 2'b00,
      NBFR_L2 = 2'b01,
      NBFR_L4 = 2'b10
   } nbfr_lane_e;

   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CMD  = 3'b001,
      ST_ADDR = 3'b010,
      ST_DATA = 3'b011,
      ST_SKIP = 3'b100
   } nbfr_state_e;

   // bits moved per serial clock for a lane setting
   function automatic logic [3:0] lane_bits(input nbfr_lane_e l);
      case (l)
         NBFR_L2: lane_bits = 4'h2;
         NBFR_L4: lane_bits = 4'h4;
         default: lane_bits = 4'h1;
      endcase
   endfunction

endpackage
